// File: hw/hsa_core.sv
// Instruction-level stack, accumulator and product transfers
`timescale 1ns/1ps
module hsa_core
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic START,
  input wire hsa_pkg::hsa_op_t OP,
  input wire logic EXT_PROG,
  input wire logic [hsa_pkg::WAIT_W-1:0] PROG_WAIT,
  input wire logic [hsa_pkg::REPEAT_W-1:0] REPEAT_COUNT,
  input wire logic [1:0] PRODUCT_SHIFT_MODE,
  input wire logic [hsa_pkg::ACC_W-1:0] PRODUCT,
  input wire logic [hsa_pkg::DMA_W-1:0] DATA_ADDR_IN,
  input wire logic [hsa_pkg::WORD_W-1:0] DATA_RD_WORD,
  input wire logic NEW_POINTER_VALID,
  input wire logic [hsa_pkg::POINTER_W-1:0] NEW_POINTER,
  input wire logic EXT_PUSH,
  input wire logic EXT_POP,
  input wire logic [hsa_pkg::WORD_W-1:0] EXT_PUSH_WORD,
  output logic BUSY,
  output logic DONE,
  output logic [hsa_pkg::ACC_W-1:0] ACC,
  output logic [hsa_pkg::WORD_W-1:0] STACK_TOP,
  output logic DATA_WR,
  output logic [hsa_pkg::DMA_W-1:0] DATA_ADDR,
  output logic [hsa_pkg::WORD_W-1:0] DATA_WR_WORD,
  output logic PC_INC,
  output logic [hsa_pkg::POINTER_W-1:0] AUX_POINTER_SELECT
);
  typedef enum {HSA_IDLE, HSA_WAIT, HSA_EXEC} hsa_state_t;

  hsa_state_t state;
  hsa_pkg::hsa_op_t op;
  logic [hsa_pkg::WAIT_W-1:0] wait_left;
  logic [hsa_pkg::REPEAT_W-1:0] reps_left;
  logic [hsa_pkg::DMA_W-1:0] addr;
  logic ptr_load;
  logic [hsa_pkg::POINTER_W-1:0] ptr_value;
  logic exec;
  logic last;
  logic st_push;
  logic st_pop;
  logic [hsa_pkg::WORD_W-1:0] st_word;
  logic [hsa_pkg::ACC_W-1:0] shifted_product;
  logic [hsa_pkg::WORD_W-1:0] top;
  logic [hsa_pkg::STACK_DEPTH*hsa_pkg::WORD_W-1:0] levels;
  logic [hsa_pkg::REPEAT_W-1:0] reps_start;

  assign reps_start = (REPEAT_COUNT == '0) ? hsa_pkg::REPEAT_ONE : REPEAT_COUNT;
  assign exec = CE && (state == HSA_EXEC);
  assign last = exec && (reps_left == hsa_pkg::REPEAT_ONE);

  // Wait states are charged once per instruction, not per repetition
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      state <= HSA_IDLE;
      op <= hsa_pkg::HSA_OP_NONE;
      wait_left <= hsa_pkg::WAIT_ZERO;
      reps_left <= hsa_pkg::REPEAT_ONE;
      addr <= '0;
      ptr_load <= 1'b0;
      ptr_value <= '0;
    end
    else if (CE)
    begin
      unique case (state)
        HSA_IDLE:
        begin
          if (START)
          begin
            op <= OP;
            addr <= DATA_ADDR_IN;
            ptr_load <= NEW_POINTER_VALID;
            ptr_value <= NEW_POINTER;
            reps_left <= reps_start;
            wait_left <= EXT_PROG ? PROG_WAIT : hsa_pkg::WAIT_ZERO;
            state <= (EXT_PROG && PROG_WAIT != hsa_pkg::WAIT_ZERO) ? HSA_WAIT : HSA_EXEC;
          end
        end
        HSA_WAIT:
        begin
          wait_left <= wait_left - 1'b1;
          if (wait_left == 4'h1)
            state <= HSA_EXEC;
        end
        HSA_EXEC:
        begin
          reps_left <= reps_left - 1'b1;
          if (reps_left == hsa_pkg::REPEAT_ONE)
            state <= HSA_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    unique case (PRODUCT_SHIFT_MODE)
      hsa_pkg::SHIFT_MODE_NONE: shifted_product = PRODUCT;
      hsa_pkg::SHIFT_MODE_LEFT1: shifted_product = PRODUCT << hsa_pkg::SHIFT_L1;
      hsa_pkg::SHIFT_MODE_LEFT4: shifted_product = PRODUCT << hsa_pkg::SHIFT_L4;
      hsa_pkg::SHIFT_MODE_RIGHT6: shifted_product = $signed(PRODUCT) >>> hsa_pkg::SHIFT_R6;
    endcase
  end

  // Sequencer ports share the stack; an executing instruction takes priority
  always_comb
  begin
    st_push = 1'b0;
    st_pop = 1'b0;
    st_word = EXT_PUSH_WORD;
    if (exec)
    begin
      unique case (op)
        hsa_pkg::HSA_OP_STACK_TO_ACC: st_pop = 1'b1;
        hsa_pkg::HSA_OP_STACK_TO_DATA: st_pop = 1'b1;
        hsa_pkg::HSA_OP_DATA_TO_STACK:
        begin
          st_push = 1'b1;
          st_word = DATA_RD_WORD;
        end
        hsa_pkg::HSA_OP_ACC_TO_STACK:
        begin
          st_push = 1'b1;
          st_word = ACC[hsa_pkg::WORD_W-1:0];
        end
        default:
        begin
          st_push = 1'b0;
          st_pop = 1'b0;
        end
      endcase
    end
    else
    begin
      st_push = EXT_PUSH;
      st_pop = EXT_POP && !EXT_PUSH;
    end
  end

  // No depth counter exists, so neither overflow nor underflow is visible
  hsa_stack u_stack
  (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .ce(CE),
    .push(st_push),
    .pop(st_pop),
    .push_word(st_word),
    .top(top),
    .levels(levels)
  );

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      ACC <= hsa_pkg::ACC_RESET;
    else if (exec && op == hsa_pkg::HSA_OP_PRODUCT_TO_ACC)
      ACC <= shifted_product;
    else if (exec && op == hsa_pkg::HSA_OP_STACK_TO_ACC)
      ACC <= {hsa_pkg::ACC_HIGH_ZERO, top};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      DATA_WR <= 1'b0;
      DATA_ADDR <= '0;
      DATA_WR_WORD <= '0;
    end
    else if (CE)
    begin
      DATA_WR <= exec && op == hsa_pkg::HSA_OP_STACK_TO_DATA;
      DATA_ADDR <= addr;
      if (exec && op == hsa_pkg::HSA_OP_STACK_TO_DATA)
        DATA_WR_WORD <= top;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      PC_INC <= 1'b0;
      DONE <= 1'b0;
      AUX_POINTER_SELECT <= '0;
    end
    else if (CE)
    begin
      PC_INC <= last;
      DONE <= last;
      if (last && ptr_load)
        AUX_POINTER_SELECT <= ptr_value;
    end
  end

  assign BUSY = (state != HSA_IDLE);
  assign STACK_TOP = top;
  // Consecutive pops since the last push; saturates so a long run cannot wrap
  logic [hsa_pkg::REPEAT_W-1:0] pop_run;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      pop_run <= '0;
    else if (CE && st_push)
      pop_run <= '0;
    else if (CE && st_pop && pop_run != '1)
      pop_run <= pop_run + 1'b1;
  end

  property pop_to_acc_p;
    @(posedge CLK_SYS) disable iff (!RSTN)
      exec && op == hsa_pkg::HSA_OP_STACK_TO_ACC
        |=> ACC == {hsa_pkg::ACC_HIGH_ZERO, $past(top)};
  endproperty
  pop_acc_load_a: assert property (pop_to_acc_p) else $error("Pop did not load low acc");

  pop_high_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && op == hsa_pkg::HSA_OP_STACK_TO_ACC |=> ACC[31:16] == hsa_pkg::ACC_HIGH_ZERO)
    else $error("Pop left upper acc nonzero");

  product_load_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && op == hsa_pkg::HSA_OP_PRODUCT_TO_ACC |=> ACC == $past(shifted_product))
    else $error("Product move wrong");

  pop_shift_up_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    CE && st_pop && !st_push |=> levels[15:0] == $past(levels[31:16])
      && levels[127:112] == $past(levels[127:112]) && levels[111:96] == $past(levels[127:112]))
    else $error("Pop shift wrong");

  push_shift_down_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    CE && st_push |=> levels[15:0] == $past(st_word)
      && levels[127:112] == $past(levels[111:96]))
    else $error("Push shift wrong");

  data_write_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && op == hsa_pkg::HSA_OP_STACK_TO_DATA |=> DATA_WR && DATA_WR_WORD == $past(top))
    else $error("Stack to data write wrong");

  acc_push_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && op == hsa_pkg::HSA_OP_ACC_TO_STACK |=> top == $past(ACC[15:0]))
    else $error("Acc push wrong");

  single_cycle_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    CE && state == HSA_IDLE && START && !EXT_PROG && REPEAT_COUNT <= 8'h01 ##1 CE
      |=> DONE && PC_INC)
    else $error("Single cycle timing wrong");

  pc_once_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    CE && PC_INC |=> !PC_INC)
    else $error("Pc advanced twice");

  smear_fill_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    int'(pop_run) >= hsa_pkg::STACK_DEPTH - 1 |-> levels == {hsa_pkg::STACK_DEPTH{top}})
    else $error("Stack not filled with bottom word");

  start_refused_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    BUSY |=> op == $past(op) && addr == $past(addr))
    else $error("Start taken while busy");

  wait_entry_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    CE && state == HSA_IDLE && START && EXT_PROG && PROG_WAIT != hsa_pkg::WAIT_ZERO
      |=> state == HSA_WAIT && wait_left == $past(PROG_WAIT))
    else $error("Wait states not entered");

  repeat_step_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && !last |=> state == HSA_EXEC && reps_left == $past(reps_left) - 1'b1)
    else $error("Repeat count step wrong");

  last_done_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    last |=> state == HSA_IDLE && DONE && PC_INC)
    else $error("Last repetition did not finish");

  write_only_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    CE && !(exec && op == hsa_pkg::HSA_OP_STACK_TO_DATA) |=> !DATA_WR)
    else $error("Stray data write");

  write_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && op == hsa_pkg::HSA_OP_STACK_TO_DATA |=> DATA_ADDR == $past(addr))
    else $error("Data write address wrong");

  acc_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !(exec && (op == hsa_pkg::HSA_OP_PRODUCT_TO_ACC || op == hsa_pkg::HSA_OP_STACK_TO_ACC))
      |=> ACC == $past(ACC))
    else $error("Acc changed without a load");

  ptr_load_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    last && ptr_load |=> AUX_POINTER_SELECT == $past(ptr_value))
    else $error("Pointer not loaded");

  ptr_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !(last && ptr_load) |=> AUX_POINTER_SELECT == $past(AUX_POINTER_SELECT))
    else $error("Pointer changed unasked");

  ce_freeze_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !CE |=> levels == $past(levels) && ACC == $past(ACC) && state == $past(state))
    else $error("State moved while clock enable low");

  stack_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && (op == hsa_pkg::HSA_OP_PRODUCT_TO_ACC || op == hsa_pkg::HSA_OP_NONE)
      |=> levels == $past(levels))
    else $error("Stack moved during a non-stack move");

  data_push_top_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && op == hsa_pkg::HSA_OP_DATA_TO_STACK |=> top == $past(DATA_RD_WORD))
    else $error("Data push top wrong");

  data_pop_shift_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    exec && op == hsa_pkg::HSA_OP_STACK_TO_DATA |=> top == $past(levels[31:16])
      && levels[127:112] == $past(levels[127:112]))
    else $error("Data pop shift wrong");

  cov_pop_c: cover property (@(posedge CLK_SYS) exec && op == hsa_pkg::HSA_OP_STACK_TO_ACC);
  cov_dpush_c: cover property (@(posedge CLK_SYS) exec && op == hsa_pkg::HSA_OP_DATA_TO_STACK);
  cov_wait_c: cover property (@(posedge CLK_SYS) state == HSA_WAIT ##1 state == HSA_EXEC);
  cov_repeat_c: cover property (@(posedge CLK_SYS) exec && !last ##1 last);
  cov_underflow_c: cover property (@(posedge CLK_SYS) int'(pop_run) > hsa_pkg::STACK_DEPTH);
endmodule : hsa_core

// File: hw/hsa_pkg.sv
// Shared constants and types for the hardware stack and accumulator move block
package hsa_pkg;
  localparam int STACK_DEPTH = 8;
  localparam int WORD_W = 16;
  localparam int ACC_W = 32;
  localparam int DMA_W = 7;
  localparam int POINTER_W = 3;
  localparam int WAIT_W = 4;
  localparam int REPEAT_W = 8;
  localparam logic [15:0] STACK_RESET = 16'h0000;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [15:0] ACC_HIGH_ZERO = 16'h0000;
  localparam logic [1:0] SHIFT_MODE_NONE = 2'h0;
  localparam logic [1:0] SHIFT_MODE_LEFT1 = 2'h1;
  localparam logic [1:0] SHIFT_MODE_LEFT4 = 2'h2;
  localparam logic [1:0] SHIFT_MODE_RIGHT6 = 2'h3;
  localparam int SHIFT_L1 = 1;
  localparam int SHIFT_L4 = 4;
  localparam int SHIFT_R6 = 6;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
  localparam logic [REPEAT_W-1:0] REPEAT_ONE = 8'h01;
  typedef enum logic [2:0] {
    HSA_OP_NONE,
    HSA_OP_PRODUCT_TO_ACC,
    HSA_OP_STACK_TO_ACC,
    HSA_OP_STACK_TO_DATA,
    HSA_OP_DATA_TO_STACK,
    HSA_OP_ACC_TO_STACK
  } hsa_op_t;
endpackage : hsa_pkg

// File: hw/hsa_stack.sv
// Eight-level last-in first-out word stack with shift-style push and pop
`timescale 1ns/1ps
module hsa_stack
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [hsa_pkg::WORD_W-1:0] push_word,
  output logic [hsa_pkg::WORD_W-1:0] top,
  output logic [hsa_pkg::STACK_DEPTH*hsa_pkg::WORD_W-1:0] levels
);
  logic [hsa_pkg::WORD_W-1:0] entry [hsa_pkg::STACK_DEPTH];

  genvar i;
  generate
    for (i = 0; i < hsa_pkg::STACK_DEPTH; i++)
    begin : g_level
      logic [hsa_pkg::WORD_W-1:0] pushed_in;
      logic [hsa_pkg::WORD_W-1:0] popped_in;
      // Neighbours chosen at elaboration, so no index ever leaves the array
      if (i == 0)
      begin : g_first
        assign pushed_in = push_word;
      end
      else
      begin : g_rest
        assign pushed_in = entry[i-1];
      end
      // Bottom copies itself, so repeated pops smear it upward
      if (i == hsa_pkg::STACK_DEPTH-1)
      begin : g_bottom
        assign popped_in = entry[i];
      end
      else
      begin : g_upper
        assign popped_in = entry[i+1];
      end
      // Oldest word falls off the bottom silently
      always_ff @(posedge clk)
      begin
        if (!rstn)
          entry[i] <= hsa_pkg::STACK_RESET;
        else if (ce && push)
          entry[i] <= pushed_in;
        else if (ce && pop)
          entry[i] <= popped_in;
      end
      assign levels[i*hsa_pkg::WORD_W +: hsa_pkg::WORD_W] = entry[i];
    end
  endgenerate

  assign top = entry[0];
endmodule : hsa_stack

// File: testbench/tb.sv
// Self-checking random testbench for the stack and accumulator move core
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0;
  logic rstn = 0;
  logic ce = 1;
  logic start = 0;
  hsa_pkg::hsa_op_t op = hsa_pkg::HSA_OP_NONE;
  logic ext_prog = 0;
  logic [3:0] p_wait = 4'h0;
  logic [7:0] rep = 8'h01;
  logic [1:0] shift_mode = 2'h0;
  logic [31:0] prod = 32'h0;
  logic [6:0] addr = 7'h0;
  logic [15:0] rd_word = 16'h0;
  logic ptr_v = 0;
  logic [2:0] ptr = 3'h0;
  logic xpush = 0;
  logic xpop = 0;
  logic [15:0] xword = 16'h0;
  logic busy, done, data_wr, pc_inc;
  logic [31:0] acc_o;
  logic [15:0] top_o, wr_word;
  logic [6:0] wr_addr;
  logic [2:0] aux_o;
  logic [15:0] stk [8];
  logic [31:0] acc;
  logic [2:0] aux;
  int miscompares = 0;
  int checks = 0;

  hsa_core DUT (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .START(start), .OP(op),
    .EXT_PROG(ext_prog), .PROG_WAIT(p_wait), .REPEAT_COUNT(rep), .PRODUCT_SHIFT_MODE(shift_mode),
    .PRODUCT(prod), .DATA_ADDR_IN(addr), .DATA_RD_WORD(rd_word), .NEW_POINTER_VALID(ptr_v),
    .NEW_POINTER(ptr), .EXT_PUSH(xpush), .EXT_POP(xpop), .EXT_PUSH_WORD(xword),
    .BUSY(busy), .DONE(done), .ACC(acc_o), .STACK_TOP(top_o), .DATA_WR(data_wr),
    .DATA_ADDR(wr_addr), .DATA_WR_WORD(wr_word), .PC_INC(pc_inc),
    .AUX_POINTER_SELECT(aux_o));

  always #5 clk_sys = ~clk_sys;

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task end_sim;
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task push_m(input logic [15:0] w);
    for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
    stk[0] = w;
  endtask : push_m

  // Bottom entry is copied upward, never cleared, so underflow repeats it
  task pop_m;
    for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
  endtask : pop_m

  function automatic logic [31:0] shifted(input logic [1:0] m, input logic [31:0] p);
    case (m)
      hsa_pkg::SHIFT_MODE_LEFT1: return p << hsa_pkg::SHIFT_L1;
      hsa_pkg::SHIFT_MODE_LEFT4: return p << hsa_pkg::SHIFT_L4;
      hsa_pkg::SHIFT_MODE_RIGHT6: return $signed(p) >>> hsa_pkg::SHIFT_R6;
      default: return p;
    endcase
  endfunction : shifted

  task run(input hsa_pkg::hsa_op_t o, input int n, input int p, input logic ext);
    int cyc, wr, inc, reps;
    logic [15:0] lw;
    reps = (n == 0) ? 1 : n;
    cyc = 0;
    wr = 0;
    inc = 0;
    lw = 16'h0;
    @(negedge clk_sys);
    op = o;
    rep = n[7:0];
    p_wait = p[3:0];
    ext_prog = ext;
    start = 1;
    @(negedge clk_sys);
    start = 0;
    while (busy === 1'b1 && cyc < 300)
    begin
      cyc++;
      wr += (data_wr === 1'b1);
      inc += (pc_inc === 1'b1);
      @(negedge clk_sys);
    end
    if (cyc >= 300)
    begin
      miscompares++;
      end_sim();
    end
    wr += (data_wr === 1'b1);
    chk("done", done, 1);
    chk("pc_inc", pc_inc, 1);
    chk("pc_inc_count", inc, 0);
    chk("cycles", cyc, reps + (ext ? p : 0));
    for (int k = 0; k < reps; k++)
    begin
      case (o)
        hsa_pkg::HSA_OP_PRODUCT_TO_ACC: acc = shifted(shift_mode, prod);
        hsa_pkg::HSA_OP_STACK_TO_ACC:
        begin
          acc = {hsa_pkg::ACC_HIGH_ZERO, stk[0]};
          pop_m();
        end
        hsa_pkg::HSA_OP_STACK_TO_DATA:
        begin
          lw = stk[0];
          pop_m();
        end
        hsa_pkg::HSA_OP_DATA_TO_STACK: push_m(rd_word);
        hsa_pkg::HSA_OP_ACC_TO_STACK: push_m(acc[15:0]);
        default: ;
      endcase
    end
    if (ptr_v)
      aux = ptr;
    if (o == hsa_pkg::HSA_OP_STACK_TO_DATA)
    begin
      chk("writes", wr, reps);
      chk("wr_word", wr_word, lw);
      chk("wr_addr", wr_addr, addr);
    end
    else
      chk("no_write", wr, 0);
    chk("acc", acc_o, acc);
    chk("top", top_o, stk[0]);
    chk("aux", aux_o, aux);
  endtask : run

  // Call and return side access while idle; push wins over pop
  task xstep(input logic pu, input logic po, input logic [15:0] w);
    @(negedge clk_sys);
    xpush = pu;
    xpop = po;
    xword = w;
    @(negedge clk_sys);
    xpush = 0;
    xpop = 0;
    if (ce && pu)
      push_m(w);
    else if (ce && po)
      pop_m();
    chk("ext_top", top_o, stk[0]);
  endtask : xstep

  initial
  begin
    void'($urandom(32'hdda1));
    foreach (stk[i]) stk[i] = hsa_pkg::STACK_RESET;
    acc = hsa_pkg::ACC_RESET;
    aux = 3'h0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1;
    chk("rst_acc", acc_o, 0);
    chk("rst_top", top_o, 0);
    // Ten pushes overflow the eight levels with no indication
    for (int i = 1; i <= 10; i++)
    begin
      rd_word = 16'h0100 + i[15:0];
      run(hsa_pkg::HSA_OP_DATA_TO_STACK, 1, 0, 0);
    end
    // Ten pops run past the bottom and keep copying it
    for (int i = 0; i < 10; i++) run(hsa_pkg::HSA_OP_STACK_TO_ACC, 1, 0, 0);
    prod = 32'h8000_1234;
    for (int m = 0; m < 4; m++)
    begin
      shift_mode = m[1:0];
      run(hsa_pkg::HSA_OP_PRODUCT_TO_ACC, 1, 0, 0);
      run(hsa_pkg::HSA_OP_ACC_TO_STACK, 1, 0, 0);
    end
    run(hsa_pkg::HSA_OP_NONE, 1, 0, 0);
    run(hsa_pkg::HSA_OP_STACK_TO_ACC, 0, 0, 0);
    addr = 7'h7f;
    run(hsa_pkg::HSA_OP_STACK_TO_DATA, 3, 2, 1);
    xstep(1, 0, 16'habcd);
    xstep(1, 1, 16'h1357);
    xstep(0, 1, 16'h0);
    ce = 0;
    xstep(1, 0, 16'hffff);
    ce = 1;
    for (int t = 0; t < 80; t++)
    begin
      shift_mode = $urandom % 4;
      prod = $urandom;
      rd_word = $urandom;
      addr = $urandom % 128;
      ptr_v = $urandom % 2;
      ptr = $urandom % 8;
      run(hsa_pkg::hsa_op_t'(1 + $urandom % 5), $urandom % 5, $urandom % 16, $urandom % 2);
    end
    end_sim();
  end
endmodule : tb
